// File: hdl/nvm_link_params.svh
// constants shared by both ends of the serial memory link
`ifndef NVM_LINK_PARAMS_SVH
`define NVM_LINK_PARAMS_SVH

// ==========================================================
// opcodes
`define NVM_OP_LATCH_SET 8'h06
`define NVM_OP_LATCH_CLEAR 8'h04
`define NVM_OP_STATUS_READ 8'h05
`define NVM_OP_STATUS_PROGRAM 8'h01
`define NVM_OP_ARRAY_READ 8'h03
`define NVM_OP_ARRAY_PROGRAM 8'h02

// ==========================================================
// status byte fields
`define NVM_ST_PROTECT_EN 7
`define NVM_ST_LOCK_HI 3
`define NVM_ST_LOCK_LO 2
`define NVM_ST_LATCH 1
`define NVM_ST_BUSY 0
`define NVM_ST_ALL_ONES 8'hff
`define NVM_PROTECT_EN_RESET 1'h0
`define NVM_LOCK_RESET 2'h0

// ==========================================================
// sizes and timing
`define NVM_ADDR_BYTES 2
`define NVM_SECTOR_BYTES 32
`define NVM_CLK_MHZ 25
`define NVM_PROG_TIME_US 5000
`define NVM_PROG_CYCLES (`NVM_PROG_TIME_US * `NVM_CLK_MHZ)

// ==========================================================
// host register map (byte addresses)
`define HOST_REG_CTRL 8'h00
`define HOST_REG_DATA 8'h04
`define HOST_REG_STAT 8'h08
`define HOST_CTRL_HOLD 0
`define HOST_CTRL_PROTECT 1
`define HOST_DATA_KEEP_CS 8
`define HOST_CTRL_RESET 2'h3
`define HOST_HALF_DIV 8

`endif

// File: hdl/nvm_pkg.sv
// types shared by both ends of the serial memory link
package nvm_pkg;
   typedef enum logic [2:0] {
      phOpcode, phAddr, phReadOut, phStatusOut, phStatusIn, phProgData,
      phIgnore
   } phase_t;
   typedef enum logic [1:0] {hsIdle, hsLow, hsHigh, hsEnd} host_state_t;
endpackage

// File: hdl/nvm_link_if.sv
// serial link between the memory controller and the memory
interface nvm_link_if;
   logic csN;
   logic sck;
   logic si;
   logic so;
   logic soOe;
   logic holdN;
   logic protectN;
   logic soLine;

   // released data line reads high through a pull-up
   assign soLine = soOe ? so : 1'b1;

   modport memory (input csN, input sck, input si, input holdN,
                   input protectN, output so, output soOe);
   modport controller (output csN, output sck, output si, output holdN,
                       output protectN, input soLine);
endinterface

// File: hdl/spi_nvm_device.sv
// serial nonvolatile memory: command decode, protection, program cycle
// Operation
// - all bytes move msb first, opcodes 8 bits
// - sample input on rise, change output on fall
// - latch-set opcode sets the enable latch
// - latch-clear opcode clears the enable latch
// - status read shifts status out, always allowed
// - status program stores protect and lock bits
// - array read takes 16-bit address, outputs byte
// - read address increments, wraps to zero
// - chip select high ends read, releases output
// - latch set needs its own selection
// - array program: address then 32 bytes
// - program starts only on exact final rise
// - host keeps the 32 bytes in one sector
// - protect pin low and enable bit block status
// - locked parts never programmed; latch gates all
// - protect enable bit cannot clear while pin low
// - busy bit reads one during program cycle
// - hold pauses the transfer, resumes later
// - status bit layout; latch and busy read-only
// - lock field selects none, quarter, half, all
// - latch clears at reset and cycle end
// - all status bits read one while busy
//
// Added by the designer: the register addresses and register access over Wishbone.
`include "nvm_link_params.svh"

module spi_nvm_device #(
   parameter int ADDR_W = 14,
   parameter int PROG_CYCLES = `NVM_PROG_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   nvm_link_if.memory link,
   output logic progBusy,
   output logic [7:0] statusView
);
   localparam int SEC_W = $clog2(`NVM_SECTOR_BYTES);
   localparam int CNT_W = $clog2(PROG_CYCLES + 1);

   generate
      if (PROG_CYCLES < 1 || ADDR_W < 8 || ADDR_W > 16) begin : badParams
         $error("spi_nvm_device: unsupported parameter values");
      end
   endgenerate

   // ==========================================================
   // input synchronisers
   logic [3:0] pinS1;
   logic [3:0] pinS2;
   logic sckD;
   logic csD;
   logic protS1;
   logic protS2;

   always_ff @(posedge clk_sys) begin
      pinS1 <= {link.csN, link.sck, link.si, link.holdN};
      pinS2 <= pinS1;
      protS1 <= link.protectN;
      protS2 <= protS1;
      sckD <= pinS2[2];
      csD <= pinS2[3];
   end

   logic csLow;
   logic sckRise;
   logic sckFall;
   logic csRise;
   logic siBit;
   assign csLow = ~pinS2[3];
   assign siBit = pinS2[1];
   assign csRise = pinS2[3] & ~csD;
   // hold low freezes the sequence where it stands
   assign sckRise = csLow & pinS2[0] & pinS2[2] & ~sckD;
   assign sckFall = csLow & pinS2[0] & ~pinS2[2] & sckD;

   // ==========================================================
   // storage and status
   logic [7:0] mem [0:(1 << ADDR_W) - 1];
   logic [7:0] sectorBuf [0:`NVM_SECTOR_BYTES - 1];
   logic protectEn;
   logic [1:0] lockLevel;
   logic enableLatch;
   logic busy;
   logic [CNT_W-1:0] busyCnt;
   logic [7:0] statusByte;
   logic hwProtect;

   assign hwProtect = ~protS2 & protectEn;
   always_comb begin
      if (busy) begin
         statusByte = `NVM_ST_ALL_ONES;
      end else begin
         statusByte = 8'h00;
         statusByte[`NVM_ST_PROTECT_EN] = protectEn;
         statusByte[`NVM_ST_LOCK_HI] = lockLevel[1];
         statusByte[`NVM_ST_LOCK_LO] = lockLevel[0];
         statusByte[`NVM_ST_LATCH] = enableLatch;
         statusByte[`NVM_ST_BUSY] = 1'b0;
      end
   end

   function automatic logic isLocked(input logic [1:0] lvl,
                                     input logic [1:0] quarter);
      case (lvl)
         2'h1: isLocked = (quarter == 2'h3);
         2'h2: isLocked = quarter[1];
         2'h3: isLocked = 1'b1;
         default: isLocked = 1'b0;
      endcase
   endfunction

   // ==========================================================
   // serial sequence engine
   nvm_pkg::phase_t phase;
   logic [2:0] bitPos;
   logic [6:0] rxShift;
   logic [7:0] rxByte;
   logic [SEC_W:0] byteCnt;
   logic [15:0] addr;
   logic [7:0] newStatus;
   logic armSet;
   logic armStatus;
   logic armProg;
   logic opClear;
   logic isRead;

   assign rxByte = {rxShift, siBit};

   always_ff @(posedge clk_sys) begin
      opClear <= 1'b0;
      if (!rst_n || !csLow) begin
         phase <= nvm_pkg::phOpcode;
         bitPos <= 3'h0;
         byteCnt <= '0;
         armSet <= 1'b0;
         armStatus <= 1'b0;
         armProg <= 1'b0;
         if (!rst_n) begin
            rxShift <= 7'h00;
            addr <= 16'h0000;
            newStatus <= 8'h00;
            isRead <= 1'b0;
         end
      end else if (sckRise) begin
         rxShift <= rxByte[6:0];
         bitPos <= bitPos + 3'h1;
         if (phase == nvm_pkg::phIgnore) begin
            // any further clock spoils a pending commit
            armSet <= 1'b0;
            armStatus <= 1'b0;
            armProg <= 1'b0;
         end
         if (bitPos == 3'h7) begin
            case (phase)
               nvm_pkg::phOpcode: begin
                  phase <= nvm_pkg::phIgnore;
                  case (rxByte)
                     `NVM_OP_LATCH_SET: armSet <= 1'b1;
                     `NVM_OP_LATCH_CLEAR: opClear <= 1'b1;
                     `NVM_OP_STATUS_READ: phase <= nvm_pkg::phStatusOut;
                     `NVM_OP_STATUS_PROGRAM: phase <= nvm_pkg::phStatusIn;
                     `NVM_OP_ARRAY_READ: begin
                        phase <= nvm_pkg::phAddr;
                        isRead <= 1'b1;
                     end
                     `NVM_OP_ARRAY_PROGRAM: begin
                        if (!busy) begin
                           phase <= nvm_pkg::phAddr;
                        end
                        isRead <= 1'b0;
                     end
                     default: phase <= nvm_pkg::phIgnore;
                  endcase
               end
               nvm_pkg::phAddr: begin
                  addr <= {addr[7:0], rxByte};
                  byteCnt <= byteCnt + 1'b1;
                  if (byteCnt == (SEC_W + 1)'(`NVM_ADDR_BYTES - 1)) begin
                     byteCnt <= '0;
                     phase <= isRead ? nvm_pkg::phReadOut
                                     : nvm_pkg::phProgData;
                  end
               end
               nvm_pkg::phReadOut: begin
                  addr <= addr + 16'h0001;
               end
               nvm_pkg::phStatusIn: begin
                  newStatus <= rxByte;
                  armStatus <= 1'b1;
                  phase <= nvm_pkg::phIgnore;
               end
               nvm_pkg::phProgData: begin
                  // bytes wrap inside the sector
                  sectorBuf[addr[SEC_W-1:0] + byteCnt[SEC_W-1:0]] <= rxByte;
                  byteCnt <= byteCnt + 1'b1;
                  if (byteCnt == (SEC_W + 1)'(`NVM_SECTOR_BYTES - 1)) begin
                     armProg <= 1'b1;
                     phase <= nvm_pkg::phIgnore;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // serial output
   logic [6:0] txShift;
   logic [7:0] txByte;
   logic outLive;
   assign txByte = (phase == nvm_pkg::phReadOut) ?
                   mem[addr[ADDR_W-1:0]] : statusByte;

   // output phase reached in this frame, so a pause can give the line back
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !csLow) begin
         outLive <= 1'b0;
      end else if (sckFall && (phase == nvm_pkg::phReadOut ||
                               phase == nvm_pkg::phStatusOut)) begin
         outLive <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n || !csLow || !pinS2[0]) begin
         link.soOe <= 1'b0;
         if (!rst_n) begin
            link.so <= 1'b0;
            txShift <= 7'h00;
         end
      end else if (sckFall && (phase == nvm_pkg::phReadOut ||
                               phase == nvm_pkg::phStatusOut)) begin
         link.soOe <= 1'b1;
         if (bitPos == 3'h0) begin
            link.so <= txByte[7];
            txShift <= txByte[6:0];
         end else begin
            link.so <= txShift[6];
            txShift <= {txShift[5:0], 1'b0};
         end
      end else if (outLive) begin
         link.soOe <= 1'b1;
      end
   end

   // ==========================================================
   // latch, status program and program cycle
   logic startStatus;
   logic startArray;
   assign startStatus = csRise & armStatus & enableLatch & ~busy &
                        ~hwProtect;
   assign startArray = csRise & armProg & enableLatch &
                       ~busy;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         enableLatch <= 1'b0;
      end else if (csRise && armSet) begin
         enableLatch <= 1'b1;
      end else if (opClear || (busy && busyCnt == '0)) begin
         enableLatch <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         busy <= 1'b0;
         busyCnt <= '0;
      end else if (startStatus || startArray) begin
         busy <= 1'b1;
         busyCnt <= CNT_W'(PROG_CYCLES - 1);
      end else if (busy) begin
         if (busyCnt == '0) begin
            busy <= 1'b0;
         end else begin
            busyCnt <= busyCnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         protectEn <= `NVM_PROTECT_EN_RESET;
         lockLevel <= `NVM_LOCK_RESET;
      end else if (startStatus) begin
         protectEn <= newStatus[`NVM_ST_PROTECT_EN];
         lockLevel <= {newStatus[`NVM_ST_LOCK_HI],
                       newStatus[`NVM_ST_LOCK_LO]};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (startArray && !isLocked(lockLevel, addr[ADDR_W-1:ADDR_W-2])) begin
         for (int i = 0; i < `NVM_SECTOR_BYTES; i++) begin
            mem[{addr[ADDR_W-1:SEC_W], SEC_W'(i)}] <= sectorBuf[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         progBusy <= 1'b0;
         statusView <= 8'h00;
      end else begin
         progBusy <= busy;
         statusView <= statusByte;
      end
   end
endmodule // spi_nvm_device

// File: hdl/spi_nvm_host.sv
// controller end: byte transfers on the serial link, wishbone registers
`include "nvm_link_params.svh"

module spi_nvm_host #(
   parameter int HALF_DIV = `HOST_HALF_DIV
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   nvm_link_if.controller link,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck
);
   localparam int DIV_W = $clog2(HALF_DIV + 1);

   generate
      if (HALF_DIV < 4) begin : badDiv
         $error("spi_nvm_host: HALF_DIV must be at least 4");
      end
   endgenerate

   // ==========================================================
   // registers
   logic [1:0] ctrl;
   logic [7:0] txByte;
   logic [7:0] rxByte;
   logic keepCs;
   logic start;
   logic active;
   logic soS1;
   logic soS2;
   logic wbReq;

   assign wbReq = wbCyc & wbStb & ~wbAck;
   assign start = wbReq & wbWe & wbSel[0] & (wbAdr == `HOST_REG_DATA) &
                  ~active;

   always_ff @(posedge clk_sys) begin
      soS1 <= link.soLine;
      soS2 <= soS1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wbAck <= 1'b0;
         wbDatR <= 32'h00000000;
         ctrl <= `HOST_CTRL_RESET;
         txByte <= 8'h00;
         keepCs <= 1'b0;
      end else begin
         wbAck <= wbReq;
         wbDatR <= 32'h00000000;
         if (wbReq && !wbWe) begin
            case (wbAdr)
               `HOST_REG_CTRL: wbDatR <= {30'h0, ctrl};
               `HOST_REG_DATA: wbDatR <= {24'h0, rxByte};
               `HOST_REG_STAT: wbDatR <= {31'h0, active};
               default: wbDatR <= 32'h00000000;
            endcase
         end
         if (wbReq && wbWe && wbSel[0] && wbAdr == `HOST_REG_CTRL) begin
            ctrl <= wbDatW[1:0];
         end
         if (start) begin
            txByte <= wbDatW[7:0];
            keepCs <= wbSel[1] & wbDatW[`HOST_DATA_KEEP_CS];
         end
      end
   end

   // ==========================================================
   // serial byte engine
   nvm_pkg::host_state_t state;
   logic [DIV_W-1:0] div;
   logic [2:0] bitIdx;
   logic [7:0] shift;
   logic tick;
   assign tick = (div == '0);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= nvm_pkg::hsIdle;
         div <= '0;
         bitIdx <= 3'h0;
         shift <= 8'h00;
         rxByte <= 8'h00;
         active <= 1'b0;
         link.csN <= 1'b1;
         link.sck <= 1'b0;
         link.si <= 1'b0;
         link.holdN <= 1'b1;
         link.protectN <= 1'b1;
      end else begin
         link.protectN <= ctrl[`HOST_CTRL_PROTECT];
         div <= tick ? DIV_W'(HALF_DIV - 1) : div - 1'b1;
         // hold changes only while the clock rests low
         if (!link.sck) begin
            link.holdN <= ctrl[`HOST_CTRL_HOLD];
         end
         case (state)
            nvm_pkg::hsIdle: begin
               if (start) begin
                  active <= 1'b1;
                  link.csN <= 1'b0;
                  link.si <= wbDatW[7];
                  shift <= {wbDatW[6:0], 1'b0};
                  bitIdx <= 3'h0;
                  div <= DIV_W'(HALF_DIV - 1);
                  state <= nvm_pkg::hsLow;
               end
            end
            nvm_pkg::hsLow: begin
               if (tick && link.holdN) begin
                  link.sck <= 1'b1;
                  state <= nvm_pkg::hsHigh;
               end
            end
            nvm_pkg::hsHigh: begin
               if (tick) begin
                  link.sck <= 1'b0;
                  rxByte <= {rxByte[6:0], soS2};
                  bitIdx <= bitIdx + 3'h1;
                  link.si <= shift[7];
                  shift <= {shift[6:0], 1'b0};
                  state <= (bitIdx == 3'h7) ? nvm_pkg::hsEnd
                                            : nvm_pkg::hsLow;
               end
            end
            nvm_pkg::hsEnd: begin
               if (tick) begin
                  // select released right after bit 0 unless keepCs holds it low
                  link.csN <= ~keepCs;
                  active <= 1'b0;
                  state <= nvm_pkg::hsIdle;
               end
            end
            default: state <= nvm_pkg::hsIdle;
         endcase
      end
   end
endmodule // spi_nvm_host

// File: verif/nvm_link_monitor.sv
// assertion checker for the serial memory link
module nvm_link_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic csN,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic soOe,
   input wire logic holdN,
   input wire logic protectN,
   input wire logic soLine
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // helper: serial clock rises within the current frame
   logic sckQ;
   logic [9:0] riseCnt;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sckQ <= 1'b0;
      end else begin
         sckQ <= sck;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n || csN) begin
         riseCnt <= 10'h0;
      end else if (sck && !sckQ) begin
         riseCnt <= riseCnt + 10'h1;
      end
   end
   // ====
   // assertions
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_FRAME_BYTES: assert property (
      $rose(csN) |-> riseCnt[2:0] == 3'h0)
      else $error("frame ended inside a byte");
   AST_SCK_IDLE: assert property (
      csN |-> !sck) else $error("serial clock high while deselected");
   AST_CS_SO_RELEASE: assert property (
      $rose(csN) |-> ##[1:5] !soOe)
      else $error("output not released after deselect");
   AST_SO_STABLE_HIGH: assert property (
      (sck && $past(sck)) |-> $stable(so))
      else $error("output changed while clock high");
   AST_SI_CHANGE_LOW: assert property (
      $changed(si) |-> !sck) else $error("input changed while clock high");
   AST_OE_START_LOW: assert property (
      $rose(soOe) |-> !sck && !csN)
      else $error("output enabled outside a low clock phase");
   AST_HOLD_CHANGE_LOW: assert property (
      $changed(holdN) |-> !sck) else $error("hold moved while clock high");
   AST_HOLD_RELEASES_SO: assert property (
      $fell(holdN) |-> ##[1:5] !soOe)
      else $error("output still driven during pause");
   C_READ_OUT: cover property ($rose(soOe));
   C_HOLD: cover property ($fell(holdN) && !csN);
   C_PROG_FRAME: cover property ($rose(csN) && riseCnt == 10'd280);
endmodule // nvm_link_monitor

// File: verif/tb_spi_nvm_command_protect.sv
// self-checking bench: controller and memory joined over the link
module tb_spi_nvm_command_protect;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] LOCK_ADR [1:3] = '{16'h2fe0, 16'h2fe0, 16'h0};
   logic clk_sys;
   logic rst_n;
   logic wbCyc;
   logic wbStb;
   logic wbWe;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatW;
   logic [31:0] wbDatR;
   logic wbAck;
   logic busyPin;
   logic [7:0] viewPin;
   logic [7:0] shadow [0:16383];
   logic [7:0] st;
   int n_fail;
   int total_checks;
   // ====
   // design and checker
   nvm_link_if link();
   spi_nvm_device #(.ADDR_W(14), .PROG_CYCLES(800)) spi_nvm_device_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(link.memory),
      .progBusy(busyPin), .statusView(viewPin));
   spi_nvm_host #(.HALF_DIV(8)) spi_nvm_host_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(link.controller),
      .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
      .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck));
   nvm_link_monitor nvm_link_monitor_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .csN(link.csN), .sck(link.sck),
      .si(link.si), .so(link.so), .soOe(link.soOe), .holdN(link.holdN),
      .protectN(link.protectN), .soLine(link.soLine));
   // ====
   // tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= d;
      do begin
         @(posedge clk_sys);
      end while (wbAck !== 1'b1);
      r = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] b, input logic keep,
                       output logic [7:0] rx);
      logic [31:0] r;
      int n;
      wb(1'b1, 8'h04, {23'h0, keep, b}, r);
      n = 0;
      do begin
         wb(1'b0, 8'h08, 32'h0, r);
         n++;
      end while (r[0] !== 1'b0 && n < 100);
      wb(1'b0, 8'h04, 32'h0, r);
      rx = r[7:0];
      if (!keep) repeat (4) @(posedge clk_sys);
   endtask
   task automatic op(input logic [7:0] b, input logic keep);
      logic [7:0] d;
      xfer(b, keep, d);
   endtask
   task automatic stat(output logic [7:0] s);
      op(8'h05, 1'b1);
      xfer(8'h00, 1'b0, s);
   endtask
   task automatic chk_stat(input logic [7:0] exp);
      logic [7:0] s;
      stat(s);
      chk(s, exp);
   endtask
   task automatic wait_idle();
      logic [7:0] s;
      int n;
      n = 0;
      do begin
         stat(s);
         n++;
      end while (s[0] !== 1'b0 && n < 40);
   endtask
   task automatic sprog(input logic [7:0] v);
      op(8'h06, 1'b0);
      op(8'h01, 1'b1);
      op(v, 1'b0);
      wait_idle();
   endtask
   task automatic prog(input logic [15:0] a, input logic [7:0] key,
                       input int nb, input logic ok);
      logic [7:0] s;
      logic [7:0] v;
      op(8'h06, 1'b0);
      op(8'h02, 1'b1);
      op(a[15:8], 1'b1);
      op(a[7:0], 1'b1);
      for (int i = 0; i < nb; i++) begin
         v = (a[7:0] + i[7:0]) ^ key;
         op(v, i != nb - 1);
         if (ok) shadow[a[13:0] + i[13:0]] = v;
      end
      stat(s);
      if (nb == 32) chk(s, 8'hff); // all ones while busy
      if (nb == 32) chk(busyPin, 1'b1); // busy output
      wait_idle();
      stat(s);
      chk(s, (nb == 32) ? st : st | 8'h02); // latch after end
      chk(viewPin, (nb == 32) ? st : st | 8'h02); // status copy
      chk(busyPin, 1'b0); // cycle over
   endtask
   task automatic rd(input logic [15:0] a, input int nb);
      logic [7:0] d;
      op(8'h03, 1'b1);
      op(a[15:8], 1'b1);
      op(a[7:0], 1'b1);
      for (int i = 0; i < nb; i++) begin
         xfer(8'h00, i != nb - 1, d);
         chk(d, shadow[a[13:0] + i[13:0]]); // stored byte
      end
   endtask
   // ====
   // clock, watchdog, tests
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (95000) @(posedge clk_sys);
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      end_sim();
   end
   initial begin
      logic [31:0] r;
      logic [7:0] s;
      rst_n = 1'b0;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 8'h00;
      wbSel = 4'hf;
      wbDatW = 32'h0;
      st = 8'h00;
      n_fail = 0;
      total_checks = 0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      wb(1'b0, 8'h00, 32'h0, r);
      chk(r, 32'h3); // control reset value
      wb(1'b0, 8'h0c, 32'h0, r);
      chk(r, 32'h0); // unmapped address reads zero
      chk_stat(8'h00); // clear after reset
      op(8'h06, 1'b0);
      chk_stat(8'h02); // latch set
      op(8'h04, 1'b0);
      chk_stat(8'h00); // latch cleared
      op(8'h06, 1'b1);
      op(8'h00, 1'b0);
      chk_stat(8'h00); // set refused with clock running on
      prog(16'h0000, 8'h11, 32, 1'b1); // sector write
      prog(16'h3fe0, 8'h22, 32, 1'b1); // top sector
      rd(16'hfffe, 4); // wrap to zero
      prog(16'h0000, 8'h33, 31, 1'b0); // short frame abandoned
      op(8'h04, 1'b0);
      rd(16'h0000, 2); // contents kept
      for (int k = 1; k < 4; k++) begin
         st = {4'h0, k[1:0], 2'h0};
         sprog(st); // lock level
         chk_stat(st); // lock field
         prog(LOCK_ADR[k], 8'h40 ^ k[7:0], 32, k == 1);
         rd(LOCK_ADR[k], 2); // level 1 sector written, locked data kept
      end
      st = 8'h8c;
      sprog(st); // protect enable and locks
      chk_stat(st); // stored
      wb(1'b1, 8'h00, 32'h1, r);
      op(8'h06, 1'b0);
      op(8'h01, 1'b1);
      op(8'h00, 1'b0);
      chk_stat(8'h8e); // refused while pin low
      wb(1'b1, 8'h00, 32'h3, r);
      op(8'h01, 1'b1);
      op(8'h00, 1'b0);
      wait_idle();
      st = 8'h00;
      chk_stat(st); // accepted with pin high
      op(8'h05, 1'b1);
      wb(1'b1, 8'h00, 32'h2, r);
      repeat (40) @(posedge clk_sys);
      wb(1'b1, 8'h00, 32'h3, r);
      xfer(8'h00, 1'b0, s);
      chk(s, st); // read resumes after pause
      end_sim();
   end
endmodule // tb_spi_nvm_command_protect
